// File: bench/tb_tof_modulation_sequencer.sv
// Testbench: shutter sequences, phases, dividers and counts of the sequencer
`timescale 1ns/1ps
module tb_tof_modulation_sequencer;
  import tof_seq_pkg::*;
  localparam int LN = 2;  // Readout lines, shortened to keep runs brief
  localparam int LC = 4;  // Cycles per readout line, shortened
  logic       core_clk_i;   // Core clock
  logic       sys_rst_i;    // Reset
  logic       hw_trig;      // Shutter pin
  logic       sw_trig;      // Shutter command from host
  host_wr_t   hbus;         // Host writes
  logic [3:0] cdiv;         // Divider field
  logic [1:0] ccnt;         // Count field
  logic [1:0] sidx;         // Running sample
  logic       busy, led, ga, gb, fs, ls;  // Status and drives
  int         num_errors;   // Mismatches
  int         checks_done;  // Comparisons

  tof_host_model tof_host_model_i (.core_clk_i(core_clk_i), .frame_sync_i(fs),
    .sw_trig_o(sw_trig), .bus_o(hbus));
  tof_modulation_sequencer #(.LINES(LN), .LINE_CYCLES(LC)) tof_modulation_sequencer_i (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hw_trig_pulse_i(hw_trig),
    .sw_trig_i(sw_trig), .host_wr_i(hbus.wr), .host_addr_i(hbus.addr),
    .host_wdata_i(hbus.data), .cur_div_o(cdiv), .cur_cnt_o(ccnt), .busy_o(busy),
    .sample_idx_o(sidx), .led_mod_o(led), .gate_a_o(ga), .gate_b_o(gb),
    .frame_sync_o(fs), .line_sync_o(ls));

  // 20 MHz clock
  initial core_clk_i = 1'b0;
  always #25 core_clk_i = ~core_clk_i;

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Counts, verdict, end of run
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Bounded wait for busy or frame sync to reach a level
  task automatic wait_on(input bit use_fs, input logic lvl);
    int n;
    for (n = 0; n < 40 && (use_fs ? fs : busy) !== lvl; n++) begin
      @(negedge core_clk_i);
    end
    check(16'(use_fs ? fs : busy), 16'(lvl));
  endtask
  // Fire a shutter and follow every frame cycle by cycle against the phase model
  task automatic run(input bit hw, input int nfr, input int dv, input int len, input bit mid);
    int k, q, f;
    if (hw) begin
      @(negedge core_clk_i);
      hw_trig = 1'b1;
      repeat (4) @(negedge core_clk_i);
      hw_trig = 1'b0;
    end else begin
      tof_host_model_i.shoot();
    end
    wait_on(1'b0, 1'b1);
    // Mid-sequence divider write and a shutter that must be ignored
    if (mid) begin
      tof_host_model_i.wr(DIV_REG_ADDR, 8'h07);
      tof_host_model_i.shoot();
    end
    for (f = 0; f < nfr; f++) begin
      wait_on(1'b1, 1'b1);
      check(16'(sidx), 16'(f));
      for (k = 0; k < len * (dv + 1); k++) begin
        q = (k / (dv + 1)) % 4;
        check(16'({fs, led}), 16'({1'b1, 1'(q < 2)}));
        check(16'({ga, gb}), 16'({1'(((q + f) % 4) < 2), 1'(((q + f) % 4) >= 2)}));
        @(negedge core_clk_i);
      end
      for (k = 0; k < LN * LC; k++) begin
        check(16'({fs, ls}), 16'((k % LC) < LC / 2));
        @(negedge core_clk_i);
      end
    end
    check(16'(fs), 16'h0);
    wait_on(1'b0, 1'b0);
    repeat (3) @(negedge core_clk_i);
    check(16'(busy), 16'h0);
  endtask

  // Reset values, then the default 47.6 us four-sample sequence at divider 1
  task automatic t_defaults();
    check(16'({cdiv, ccnt}), 16'({DIV_RESET, CNT_RESET}));
    check(16'({busy, led, ga, gb, fs, ls}), 16'h0);
    // Host roll-over fold: above span, below zero, inside
    check(16'(tof_host_model_i.fold(130, 125)), 16'h0005);
    check(16'(tof_host_model_i.fold(-3, 125)), 16'h007A);
    check(16'(tof_host_model_i.fold(60, 125)), 16'h003C);
    run(1'b0, 4, 1, 476, 1'b0);
    $display("Test defaults done");
  endtask
  // Rewrite the table between frames, then a pin-triggered sequence
  task automatic t_table();
    int s;
    for (s = 0; s < 4; s++) begin
      tof_host_model_i.wr_tbl(TBL_FIRST_ADDR + 8'(2 * s), 8'h08);
      tof_host_model_i.wr_tbl(TBL_FIRST_ADDR + 8'(2 * s + 1), 8'h00);
    end
    run(1'b1, 4, 1, 8, 1'b0);
    // LED drive switched off in the control byte; gates keep running
    tof_host_model_i.wr_tbl(TBL_FIRST_ADDR + 8'(TBL_CTRL_IDX), 8'h00);
    tof_host_model_i.shoot();
    wait_on(1'b1, 1'b1);
    repeat (8) begin
      check(16'({led, ga ^ gb}), 16'h0001);
      @(negedge core_clk_i);
    end
    repeat (100) @(negedge core_clk_i);
    check(16'(busy), 16'h0000);
    tof_host_model_i.wr_tbl(TBL_FIRST_ADDR + 8'(TBL_CTRL_IDX), 8'h01);
    $display("Test table done");
  endtask
  // Count codes CNT_TWO, CNT_ONE and the spare code 3
  task automatic t_counts();
    logic [1:0] code [3] = '{CNT_TWO, CNT_ONE, 2'h3};
    int         nfr  [3] = '{2, 1, 4};
    int i;
    for (i = 0; i < 3; i++) begin
      tof_host_model_i.wr(CNT_REG_ADDR, 8'(code[i]));
      check(16'(ccnt), 16'(code[i]));
      run(1'b0, nfr[i], 1, 8, 1'b0);
    end
    $display("Test counts done");
  endtask
  // Every documented divider, two samples each
  task automatic t_dividers();
    logic [3:0] dv [5] = '{DIV_96MHZ, DIV_48MHZ, DIV_24MHZ, DIV_12MHZ, DIV_6MHZ};
    int i;
    tof_host_model_i.wr(CNT_REG_ADDR, 8'(CNT_TWO));
    for (i = 0; i < 5; i++) begin
      tof_host_model_i.wr(DIV_REG_ADDR, 8'(dv[i]));
      check(16'(cdiv), 16'(dv[i]));
      run(1'b0, 2, int'(dv[i]), 8, 1'b0);
    end
    $display("Test dividers done");
  endtask
  // Settings written mid-sequence wait for the next shutter
  task automatic t_midseq();
    tof_host_model_i.wr(DIV_REG_ADDR, 8'(DIV_48MHZ));
    run(1'b0, 2, 1, 8, 1'b1);
    check(16'(cdiv), 16'h7);
    run(1'b0, 2, 7, 8, 1'b0);
    $display("Test midseq done");
  endtask

  // Main sequence
  initial begin
    num_errors = 0;
    checks_done = 0;
    hw_trig = 1'b0;
    sys_rst_i = 1'b1;
    repeat (10) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    t_defaults();
    t_table();
    t_counts();
    t_dividers();
    t_midseq();
    wrap_up();
  end
  // Watchdog, about six times the expected run
  initial begin
    #(30000 * 50);
    num_errors++;
    wrap_up();
  end
endmodule

// File: bench/tof_host_model.sv
// Partner model: host controller that programs the sequencer and fires shutters
`timescale 1ns/1ps
module tof_host_model
  import tof_seq_pkg::*;
(
  input  wire logic core_clk_i,    // Core clock
  input  wire logic frame_sync_i,  // Integration in progress
  output logic      sw_trig_o,     // Shutter command strobe
  output host_wr_t  bus_o          // Register write bundle
);
  // Quiet bus at time zero
  initial begin
    bus_o = '0;
    sw_trig_o = 1'b0;
  end
  // One write per call, back to back well inside the readout window
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    bus_o = '{wr: 1'b1, addr: a, data: d};
    @(negedge core_clk_i);
    // Released lines flip so a stale value never looks valid
    bus_o = '{wr: 1'b0, addr: ~a, data: ~d};
  endtask
  // Table bytes only go out once integration has ended
  task automatic wr_tbl(input logic [7:0] a, input logic [7:0] d);
    int n;
    for (n = 0; n < 2000 && frame_sync_i !== 1'b0; n++) begin
      @(negedge core_clk_i);
    end
    wr(a, d);
  endtask
  // Shutter command, one cycle wide
  task automatic shoot();
    @(negedge core_clk_i);
    sw_trig_o = 1'b1;
    @(negedge core_clk_i);
    sw_trig_o = 1'b0;
  endtask
  // Distance fold back into one unambiguity span
  function automatic int fold(input int d, input int span);
    return (d > span) ? d - span : (d < 0) ? d + span : d;
  endfunction
endmodule

// File: bench/tof_seq_assertions.sv
// Checker: port-level timing and phase properties of the modulation sequencer
`timescale 1ns/1ps
module tof_seq_assertions
  import tof_seq_pkg::*;
(
  input wire logic       core_clk_i,       // Core clock
  input wire logic       sys_rst_i,        // Synchronous reset
  input wire logic       hw_trig_pulse_i,  // Shutter pin
  input wire logic       sw_trig_i,        // Shutter command
  input wire logic       host_wr_i,        // Host write strobe
  input wire logic [7:0] host_addr_i,      // Host address
  input wire logic [7:0] host_wdata_i,     // Host data
  input wire logic [3:0] cur_div_o,        // Divider field
  input wire logic [1:0] cur_cnt_o,        // Count field
  input wire logic       busy_o,           // Sequence running
  input wire logic [1:0] sample_idx_o,     // Running sample
  input wire logic       led_mod_o,        // LED drive
  input wire logic       gate_a_o,         // First gate
  input wire logic       gate_b_o,         // Second gate
  input wire logic       frame_sync_o,     // Integration window
  input wire logic       line_sync_o       // Readout line marker
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Both gates come from one modulator, so they never overlap
  property p_gate_comp; frame_sync_o |-> gate_b_o == !gate_a_o; endproperty
  a_gate_comp: assert property (p_gate_comp)
    else $error("gates not complementary");
  // Drives rest low between integrations, keeping the pixels quiet
  property p_idle_quiet; !frame_sync_o |-> !(led_mod_o || gate_a_o || gate_b_o); endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("drive active outside integration");
  // Idle shutter command starts a sequence one cycle later
  property p_trig_busy; sw_trig_i && !busy_o |=> busy_o; endproperty
  a_trig_busy: assert property (p_trig_busy)
    else $error("shutter not taken");
  // Table load takes ten cycles before the first integration
  property p_load_len; $rose(busy_o) |-> ##10 $rose(frame_sync_o); endproperty
  a_load_len: assert property (p_load_len)
    else $error("first integration late or early");
  // A sequence opens with sample zero
  property p_first; $rose(busy_o) |-> sample_idx_o == 2'h0; endproperty
  a_first: assert property (p_first)
    else $error("sequence not started at sample zero");
  // Sample index only steps upwards by one inside a sequence
  property p_ascend;
    busy_o && $past(busy_o) && $changed(sample_idx_o) |->
      sample_idx_o == $past(sample_idx_o) + 2'h1;
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("sample order broken");
  // Sample zero: LED in phase with the first gate
  property p_s0; frame_sync_o && sample_idx_o == 2'h0 && led_mod_o |-> gate_a_o; endproperty
  a_s0: assert property (p_s0)
    else $error("sample zero phase wrong");
  // Sample one: first gate rises a quarter before the LED does
  property p_s1;
    frame_sync_o && $past(frame_sync_o) && sample_idx_o == 2'h1 && $rose(gate_a_o)
      |-> !led_mod_o;
  endproperty
  a_s1: assert property (p_s1)
    else $error("sample one phase wrong");
  // Sample two: gates swapped, LED against the first gate
  property p_s2; frame_sync_o && sample_idx_o == 2'h2 && led_mod_o |-> !gate_a_o; endproperty
  a_s2: assert property (p_s2)
    else $error("sample two phase wrong");
  // Divider field follows its register write
  property p_div_wr;
    host_wr_i && host_addr_i == DIV_REG_ADDR |=> cur_div_o == $past(host_wdata_i[3:0]);
  endproperty
  a_div_wr: assert property (p_div_wr)
    else $error("divider write lost");
  // Count field follows its register write
  property p_cnt_wr;
    host_wr_i && host_addr_i == CNT_REG_ADDR |=> cur_cnt_o == $past(host_wdata_i[1:0]);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr)
    else $error("count write lost");
endmodule

bind tof_modulation_sequencer tof_seq_assertions tof_seq_assertions_i (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hw_trig_pulse_i(hw_trig_pulse_i),
  .sw_trig_i(sw_trig_i), .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
  .host_wdata_i(host_wdata_i), .cur_div_o(cur_div_o), .cur_cnt_o(cur_cnt_o),
  .busy_o(busy_o), .sample_idx_o(sample_idx_o), .led_mod_o(led_mod_o),
  .gate_a_o(gate_a_o), .gate_b_o(gate_b_o), .frame_sync_o(frame_sync_o),
  .line_sync_o(line_sync_o));

// File: inc/tof_seq_pkg.sv
// Package: constants, types and defaults shared by the modulation sequencer files
package tof_seq_pkg;

  // Core clock period; the core clock stands in for the undivided modulator clock
  localparam int unsigned CLK_PERIOD_NS  = 50;

  // Modulation table: host register addresses and table geometry
  localparam logic [7:0]  TBL_FIRST_ADDR = 8'h22;
  localparam logic [7:0]  TBL_LAST_ADDR  = 8'h2D;
  localparam int unsigned TBL_DEPTH      = 12;
  localparam int unsigned TBL_AW         = 4;
  localparam int unsigned TBL_DW         = 8;

  // Table layout: bytes 2s/2s+1 = integration length of sample s, byte 8 = control
  localparam logic [3:0]  TBL_CTRL_IDX   = 4'h8;
  localparam int unsigned TBL_CTRL_LED   = 0;
  localparam logic [3:0]  TBL_LOAD_LAST  = 4'h8;

  // Host-side register addresses for the loose configuration fields
  localparam logic [7:0]  DIV_REG_ADDR   = 8'h85;
  localparam logic [7:0]  CNT_REG_ADDR   = 8'h92;

  // Divider settings: mod clock = base / (div + 1); multiplier of time base = div + 1
  localparam logic [3:0]  DIV_96MHZ      = 4'h0;
  localparam logic [3:0]  DIV_48MHZ      = 4'h1;
  localparam logic [3:0]  DIV_24MHZ      = 4'h3;
  localparam logic [3:0]  DIV_12MHZ      = 4'h7;
  localparam logic [3:0]  DIV_6MHZ       = 4'hF;
  localparam logic [3:0]  DIV_RESET      = DIV_48MHZ;

  // Correlation-sample count field encodings
  localparam logic [1:0]  CNT_ONE        = 2'h0;
  localparam logic [1:0]  CNT_TWO        = 2'h1;
  localparam logic [1:0]  CNT_FOUR       = 2'h2;
  localparam logic [1:0]  CNT_RESET      = CNT_FOUR;

  // Default integration time and its length in modulation ticks at the reset divider
  localparam int unsigned INT_TIME_NS    = 47600;
  localparam int unsigned INT_TICKS_DEF  =
    INT_TIME_NS / CLK_PERIOD_NS / (int'(DIV_RESET) + 1);
  localparam logic [15:0] INT_LEN_RESET  = 16'(INT_TICKS_DEF);
  localparam logic [7:0]  CTRL_RESET     = 8'h01;

  // Quarters of the four-quarter period in which the square waves are high (first half)
  localparam logic [1:0]  PH_QUARTERS    = 2'h2;

  // Configuration carried from host fields into the sequencer
  typedef struct packed {
    logic [3:0] div;  // Modulation clock divider
    logic [1:0] cnt;  // Correlation-sample count code
  } seq_cfg_t;

  // Host write strobe bundle for the modulation table and fields
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } host_wr_t;

  // Drive outputs toward the illumination driver and the pixel field
  typedef struct packed {
    logic led;
    logic gate_a;
    logic gate_b;
  } mod_out_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_INTEG,
    ST_READOUT
  } seq_state_t;

endpackage

// File: verilog/tof_mod_table.sv
// Modulation table memory: host-written bytes with registered read data
`timescale 1ns/1ps
module tof_mod_table
  import tof_seq_pkg::*;
#(
  parameter int unsigned DEPTH = TBL_DEPTH
) (
  input  wire logic              core_clk_i,  // Core clock
  input  wire logic              sys_rst_i,   // Synchronous reset, active high
  input  wire logic              wr_i,        // Write strobe, one cycle
  input  wire logic [TBL_AW-1:0] waddr_i,     // Write index
  input  wire logic [TBL_DW-1:0] wdata_i,     // Write data
  input  wire logic [TBL_AW-1:0] raddr_i,     // Read index
  output logic      [TBL_DW-1:0] rdata_o      // Read data, one cycle after raddr_i
);

  // Reset image: every sample gets the default length, LED drive enabled
  function automatic logic [TBL_DW-1:0] reset_byte(input int unsigned idx);
    if (idx == int'(TBL_CTRL_IDX)) begin
      return CTRL_RESET;
    end else if (idx % 2 == 0) begin
      return INT_LEN_RESET[7:0];
    end else begin
      return INT_LEN_RESET[15:8];
    end
  endfunction

  typedef struct packed {
    logic [DEPTH-1:0][TBL_DW-1:0] mem;    // Table bytes
    logic [TBL_DW-1:0]            rdata;  // Registered read data
  } tbl_state_t;

  tbl_state_t st_ff;   // Registered state
  tbl_state_t nxt_st;  // Next state

  // Write port and registered read; a read of the address being written sees old data
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = (32'(raddr_i) < DEPTH) ? st_ff.mem[raddr_i] : '0;
    if (wr_i && 32'(waddr_i) < DEPTH) begin
      nxt_st.mem[waddr_i] = wdata_i;
    end
  end

  // State register with reset image
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < int'(DEPTH); i++) begin
        st_ff.mem[i] <= reset_byte(i);
      end
      st_ff.rdata <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;

endmodule

// File: verilog/tof_modulation_sequencer.sv
// Modulation sequencer: mod clock divider, LED drive, demodulation gates, frame sequencing
`timescale 1ns/1ps
module tof_modulation_sequencer
  import tof_seq_pkg::*;
#(
  parameter int unsigned LINES       = 240,  // Readout lines per frame
  parameter int unsigned LINE_CYCLES = 64    // Core cycles per readout line
) (
  input  wire logic       core_clk_i,       // Core clock, 20 MHz
  input  wire logic       sys_rst_i,        // Synchronous reset, active high
  input  wire logic       hw_trig_pulse_i,  // Hardware shutter pin, asynchronous
  input  wire logic       sw_trig_i,        // Shutter command strobe, one cycle
  input  wire logic       host_wr_i,        // Host register write strobe
  input  wire logic [7:0] host_addr_i,      // Host register address
  input  wire logic [7:0] host_wdata_i,     // Host register write data
  output logic      [3:0] cur_div_o,        // Divider field as programmed
  output logic      [1:0] cur_cnt_o,        // Sample-count field as programmed
  output logic            busy_o,           // Sequence in progress
  output logic      [1:0] sample_idx_o,     // Correlation sample now running
  output logic            led_mod_o,        // Illumination modulation drive
  output logic            gate_a_o,         // First demodulation gate
  output logic            gate_b_o,         // Second demodulation gate
  output logic            frame_sync_o,     // High during integration of a frame
  output logic            line_sync_o       // High in first half of each readout line
);

  localparam int unsigned LINE_W = $clog2(LINES + 1);
  localparam int unsigned CYC_W  = $clog2(LINE_CYCLES + 1);
  localparam logic [LINE_W-1:0] LINES_LAST = LINE_W'(LINES - 1);
  localparam logic [CYC_W-1:0]  CYC_LAST   = CYC_W'(LINE_CYCLES - 1);
  localparam logic [CYC_W-1:0]  CYC_HALF   = CYC_W'(LINE_CYCLES / 2);

  // Number of frames for a count code; codes 10 and 11 both mean four
  function automatic logic [2:0] frames_of(input logic [1:0] code);
    unique case (code)
      CNT_ONE: return 3'h1;
      CNT_TWO: return 3'h2;
      default: return 3'h4;
    endcase
  endfunction

  // Square wave high in the first half of a four-quarter period
  function automatic logic sq_wave(input logic [1:0] quarter);
    return quarter < PH_QUARTERS;
  endfunction

  // Map a host address into the table index; valid flag on bit 4
  function automatic logic [TBL_AW:0] tbl_index(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - TBL_FIRST_ADDR;
    if (addr >= TBL_FIRST_ADDR && addr <= TBL_LAST_ADDR) begin
      return {1'b1, off[TBL_AW-1:0]};
    end
    return '0;
  endfunction

  // Complete sequencer state
  typedef struct packed {
    seq_cfg_t                             cfg;       // Host-visible fields
    seq_cfg_t                             act;       // Fields latched at sequence start
    seq_state_t                           state;     // Sequencer state
    logic [TBL_AW-1:0]                    ld_idx;    // Table load index
    logic [int'(TBL_LOAD_LAST):0][7:0]    shadow;    // Table copy for this sequence
    logic [1:0]                           sample;    // Current correlation sample
    logic [2:0]                           frames;    // Frames in this sequence
    logic [3:0]                           div_cnt;   // Modulation tick divider
    logic [1:0]                           quarter;   // Quarter of LED period
    logic [15:0]                          integ;     // Integration ticks elapsed
    logic [LINE_W-1:0]                    line;      // Readout line
    logic [CYC_W-1:0]                     cyc;       // Cycle within a line
    logic [2:0]                           trig_sync; // Pin synchroniser and edge stage
    mod_out_t                             drive;     // Registered drive outputs
    logic                                 fsync;     // Registered frame sync
    logic                                 lsync;     // Registered line sync
  } seq_st_t;

  seq_st_t          st_ff;     // Registered state
  seq_st_t          nxt_st;    // Next state
  host_wr_t         hw;        // Host write bundle
  logic [TBL_AW:0]  wr_idx;    // Decoded table write index with valid
  logic [7:0]       tbl_rdata; // Table read data
  logic             trig;      // Qualified shutter event
  logic             tick;      // Modulation clock tick
  logic             enable_led;// LED drive enabled for this sequence
  logic [1:0]       ph_off;    // Gate A quarter offset for this sample
  logic [15:0]      len_now;   // Integration length of current sample
  logic [1:0]       gate_q;    // Gate A quarter position

  assign hw     = '{wr: host_wr_i, addr: host_addr_i, data: host_wdata_i};
  assign wr_idx = tbl_index(hw.addr);

  // Table writes are always accepted; the sequencer only reads them when loading
  tof_mod_table #(
    .DEPTH (TBL_DEPTH)
  ) u_table (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .wr_i       (hw.wr && wr_idx[TBL_AW]),
    .waddr_i    (wr_idx[TBL_AW-1:0]),
    .wdata_i    (hw.data),
    .raddr_i    (st_ff.ld_idx),
    .rdata_o    (tbl_rdata)
  );

  // Rising edge of the synchronised pin; stage 0 feeds only stage 1
  assign trig = (st_ff.trig_sync[1] && !st_ff.trig_sync[2]) || sw_trig_i;

  // Modulation clock tick once every div+1 core cycles
  assign tick = (st_ff.div_cnt == st_ff.act.div);

  // Per-sample integration length from the shadow copy
  assign len_now    = {st_ff.shadow[{st_ff.sample, 1'b1}], st_ff.shadow[{st_ff.sample, 1'b0}]};

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;

    // Pin synchroniser, two flops plus one edge stage
    nxt_st.trig_sync = {st_ff.trig_sync[1:0], hw_trig_pulse_i};

    // Host field writes; they only reach the modulator at the next sequence start
    if (hw.wr && hw.addr == DIV_REG_ADDR) begin
      nxt_st.cfg.div = hw.data[3:0];
    end
    if (hw.wr && hw.addr == CNT_REG_ADDR) begin
      nxt_st.cfg.cnt = hw.data[1:0];
    end

    // Divider and quarter counters run freely so the modulator is always live
    if (tick) begin
      nxt_st.div_cnt = '0;
      nxt_st.quarter = st_ff.quarter + 2'h1;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 4'h1;
    end

    unique case (st_ff.state)
      // Wait for a shutter; latch fields so later writes cannot disturb this run
      ST_IDLE: begin
        if (trig) begin
          nxt_st.act    = st_ff.cfg;
          nxt_st.frames = frames_of(st_ff.cfg.cnt);
          nxt_st.sample = '0;
          nxt_st.ld_idx = '0;
          nxt_st.div_cnt = '0;
          nxt_st.state  = ST_LOAD;
        end
      end
      // Copy the table into the shadow; read data trails the index by one cycle
      ST_LOAD: begin
        if (st_ff.ld_idx != '0) begin
          nxt_st.shadow[st_ff.ld_idx - 4'h1] = tbl_rdata;
        end
        if (st_ff.ld_idx == TBL_LOAD_LAST + 4'h1) begin
          nxt_st.state   = ST_INTEG;
          nxt_st.div_cnt = '0;
          nxt_st.quarter = '0;
          nxt_st.integ   = '0;
        end else begin
          nxt_st.ld_idx = st_ff.ld_idx + 4'h1;
        end
      end
      // Integrate for the sample length in modulation ticks; slower clock = longer base
      ST_INTEG: begin
        if (tick) begin
          nxt_st.integ = st_ff.integ + 16'h1;
          if (st_ff.integ + 16'h1 >= len_now) begin
            nxt_st.state = ST_READOUT;
            nxt_st.line  = '0;
            nxt_st.cyc   = '0;
          end
        end
      end
      // Readout lines; the next sample follows at once, no new trigger needed
      ST_READOUT: begin
        if (st_ff.cyc == CYC_LAST) begin
          nxt_st.cyc  = '0;
          nxt_st.line = st_ff.line + LINE_W'(1);
          if (st_ff.line == LINES_LAST) begin
            if (3'(st_ff.sample) + 3'h1 >= st_ff.frames) begin
              nxt_st.state = ST_IDLE;
            end else begin
              nxt_st.sample  = st_ff.sample + 2'h1;
              nxt_st.state   = ST_INTEG;
              nxt_st.div_cnt = '0;
              nxt_st.quarter = '0;
              nxt_st.integ   = '0;
            end
          end
        end else begin
          nxt_st.cyc = st_ff.cyc + CYC_W'(1);
        end
      end
    endcase

    // Gate A runs sample*90 deg away from the LED; samples 2, 3 invert it = swap gates.
    // Taken from the next state so the drives start and stop together with frame sync.
    enable_led = nxt_st.shadow[TBL_CTRL_IDX][TBL_CTRL_LED];
    ph_off     = nxt_st.sample;
    gate_q     = nxt_st.quarter + ph_off;

    // Drive outputs: one quarter counter feeds LED and both gates
    if (nxt_st.state == ST_INTEG) begin
      nxt_st.drive.led    = enable_led && sq_wave(nxt_st.quarter);
      nxt_st.drive.gate_a = sq_wave(gate_q);
      nxt_st.drive.gate_b = !sq_wave(gate_q);
    end else begin
      nxt_st.drive = '0;
    end

    // Frame sync falls when integration ends, marking the safe write point
    nxt_st.fsync = (nxt_st.state == ST_INTEG);
    nxt_st.lsync = (nxt_st.state == ST_READOUT) && (nxt_st.cyc < CYC_HALF);
  end

  // State register; reset gives 48 MHz, four samples, default table
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_ff         <= '0;
      st_ff.cfg.div <= DIV_RESET;
      st_ff.cfg.cnt <= CNT_RESET;
      st_ff.act.div <= DIV_RESET;
      st_ff.act.cnt <= CNT_RESET;
      st_ff.state   <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs, all from flip-flops except busy_o, decoded from the state register
  assign cur_div_o    = st_ff.cfg.div;
  assign cur_cnt_o    = st_ff.cfg.cnt;
  assign busy_o       = (st_ff.state != ST_IDLE);
  assign sample_idx_o = st_ff.sample;
  assign led_mod_o    = st_ff.drive.led;
  assign gate_a_o     = st_ff.drive.gate_a;
  assign gate_b_o     = st_ff.drive.gate_b;
  assign frame_sync_o = st_ff.fsync;
  assign line_sync_o  = st_ff.lsync;

endmodule
